// ### core/dmx_addr_resolve.sv
`include "dmx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dmx_addr_resolve
(
	input  wire logic [7:0]  low,
	input  wire logic        abit,
	input  wire logic [3:0]  bank_low,
	input  wire logic        ext_en,
	input  wire logic [11:0] fsr2,
	output logic      [11:0] addr
);
	// Turns an 8-bit file address into a data space address
	always_comb
	begin
		if (abit)
			addr = {bank_low, low};
		else if (ext_en && (low <= `DMX_ILO_LIMIT))
			addr = fsr2 + {`DMX_LIT_PAD, low}; // Wraps in 4 KB
		else if (low < `DMX_ACCESS_SPLIT)
			addr = {`DMX_ACCESS_LO, low};
		else
			addr = {`DMX_ACCESS_HI, low};
	end
endmodule
`default_nettype wire

// ### core/dmx_cfg.svh
`ifndef DMX_CFG_SVH
`define DMX_CFG_SVH
// Opcode prefixes of the data-move group
`define DMX_PFX_COPY     4'hC
`define DMX_PFX_DEST     4'hF
`define DMX_PFX_MOVE     6'h14
`define DMX_PFX_STORE    7'h37
`define DMX_PFX_LDBANK   8'h01
`define DMX_PFX_LDACC    8'h0E
// Field positions inside an instruction word
`define DMX_POS_DBIT     9
`define DMX_POS_ABIT     8
// Addressing limits and page numbers
`define DMX_ILO_LIMIT    8'h5F
`define DMX_ACCESS_SPLIT 8'h60
`define DMX_ACCESS_LO    4'h0
`define DMX_ACCESS_HI    4'hF
`define DMX_BANK_CLR     4'h0
`define DMX_LIT_PAD      4'h0
// Reset values and the zero-flag compare byte
`define DMX_ACC_RST      8'h00
`define DMX_BANK_RST     8'h00
`define DMX_HOLD_RST     8'h00
`define DMX_ADDR_RST     12'h000
`define DMX_ZERO_BYTE    8'h00
// Accumulator location in the data space
`define DMX_W_ADDR_DEF   12'hFFF
`endif

// ### core/dmx_dec_if.sv
`timescale 1ns/1ns
`default_nettype none
// Fetched word out, decoded fields back
interface dmx_dec_if;
	import dmx_pkg::*;
	logic [15:0] word;
	dmx_op_t     op;
	logic        dbit;
	logic        abit;
	logic [7:0]  low;
	logic [11:0] far;
	logic        dest_word;
	modport dec (input word, output op, dbit, abit, low, far, dest_word);
	modport exe (output word, input op, dbit, abit, low, far, dest_word);
endinterface
`default_nettype wire

// ### core/dmx_decoder.sv
`include "dmx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dmx_decoder
	import dmx_pkg::*;
(
	dmx_dec_if.dec d
);
	// Prefix match, longest prefixes are disjoint so order is free
	always_comb
	begin
		d.op = DMX_OP_NONE;
		if (d.word[15:12] == `DMX_PFX_COPY)
			d.op = DMX_OP_COPY1;
		else if (d.word[15:10] == `DMX_PFX_MOVE)
			d.op = DMX_OP_MOVE;
		else if (d.word[15:9] == `DMX_PFX_STORE)
			d.op = DMX_OP_STORE;
		else if (d.word[15:8] == `DMX_PFX_LDBANK)
			d.op = DMX_OP_LDBANK;
		else if (d.word[15:8] == `DMX_PFX_LDACC)
			d.op = DMX_OP_LDACC;
	end

	// Operand fields
	assign d.dbit      = d.word[`DMX_POS_DBIT];
	assign d.abit      = d.word[`DMX_POS_ABIT];
	assign d.low       = d.word[7:0];
	assign d.far       = d.word[11:0];
	assign d.dest_word = (d.word[15:12] == `DMX_PFX_DEST);
endmodule
`default_nettype wire

// ### core/dmx_move_exec.sv
`include "dmx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1: Full-space copy is two words, prefixes 1100 then 1111, two cycles.
// RULE2: Full-space copy moves source byte to destination, any 12-bit address.
// RULE3: Full-space copy treats the accumulator like any data location.
// RULE4: Software never targets PC low or return-stack bytes with the copy.
// RULE5: Bank load is one cycle, prefix 0000 0001, writes bank in Q4.
// RULE6: Bank selector upper nibble always ends up zero after bank load.
// RULE7: Accumulator literal load, prefix 0000 1110, puts literal in acc.
// RULE8: Accumulator store, prefix 0110 111a, writes acc to file register.
// RULE9: Store with bank bit 0 addresses the access bank.
// RULE10: Store with bank bit 1 uses the bank selector.
// RULE11: Extended set, bank bit 0, address up to 5Fh: indexed offset.
// RULE12: Register move goes to acc when d is 0, back to register when 1.
// RULE13: Register move, prefix 0101 00da, sets negative and zero flags.
// RULE14: Copy, bank load, literal load and store keep all flags.
module dmx_move_exec
	import dmx_pkg::*;
#(
	parameter logic [11:0] W_ADDR = `DMX_W_ADDR_DEF
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	output logic             instr_ready,
	input  wire logic        ext_set_en,
	input  wire logic [11:0] fsr2,
	output logic      [11:0] mem_addr,
	output logic             mem_re,
	output logic             mem_we,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	output logic      [7:0]  acc_value,
	output logic      [7:0]  bank_value,
	output logic             flag_n,
	output logic             flag_z,
	output logic             foreign_word,
	output logic             broken_copy
);
	dmx_phase_t  phase_reg;
	dmx_phase_t  phase_next;
	dmx_op_t     op_reg;
	logic        pend_reg;
	logic        dbit_reg;
	logic        foreign_reg;
	logic        broken_reg;
	logic        n_reg;
	logic        z_reg;
	logic [7:0]  hold_reg;
	logic [7:0]  acc_reg;
	logic [7:0]  bank_reg;
	logic [11:0] addr_reg;
	logic [11:0] res_addr;
	logic        take;
	logic        addr_w;
	logic        rd_mem;
	logic        wr_any;
	logic        wr_mem;

	dmx_dec_if dec_bus ();

	// Decoder looks at the raw fetch word
	assign dec_bus.word = instr_word;

	dmx_decoder u_dec
	(
		.d (dec_bus.dec)
	);

	// Bank selector is read at Q1, always settled by the prior Q4
	dmx_addr_resolve u_res
	(
		.low      (dec_bus.low),
		.abit     (dec_bus.abit),
		.bank_low (bank_reg[3:0]),
		.ext_en   (ext_set_en),
		.fsr2     (fsr2),
		.addr     (res_addr)
	);

	// Fetch handshake: a word is taken only in Q1
	assign instr_ready = (phase_reg == DMX_Q1);
	assign take        = instr_ready && instr_valid;

	// Accumulator is mapped into the data space at W_ADDR
	assign addr_w = (addr_reg == W_ADDR); // [RULE3]

	// Memory strobes, read in Q2 and write in Q4
	assign rd_mem = (phase_reg == DMX_Q2) && !addr_w &&
		((op_reg == DMX_OP_MOVE) || (op_reg == DMX_OP_COPY1));
	assign wr_any = (phase_reg == DMX_Q4) &&
		(((op_reg == DMX_OP_MOVE) && dbit_reg) ||
		(op_reg == DMX_OP_COPY2) || (op_reg == DMX_OP_STORE));
	assign wr_mem = wr_any && !addr_w;

	assign mem_addr     = addr_reg;
	assign mem_wdata    = hold_reg;
	assign mem_re       = rd_mem;
	assign mem_we       = wr_mem;
	assign acc_value    = acc_reg;
	assign bank_value   = bank_reg;
	assign flag_n       = n_reg;
	assign flag_z       = z_reg;
	assign foreign_word = foreign_reg;
	assign broken_copy  = broken_reg;

	// Phase sequencer; waits in Q1 only for the copy's second word
	always_comb
	begin
		case (phase_reg)
			DMX_Q1:
				phase_next = (pend_reg && !instr_valid) ? DMX_Q1 : DMX_Q2;
			DMX_Q2:
				phase_next = DMX_Q3;
			DMX_Q3:
				phase_next = DMX_Q4;
			DMX_Q4:
				phase_next = DMX_Q1;
			default:
				phase_next = DMX_Q1;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			phase_reg <= DMX_Q1;
		else
			phase_reg <= phase_next;
	end

	// Decode latch; an idle Q1 turns the cycle into a no-op
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_reg   <= DMX_OP_NONE;
			dbit_reg <= 1'b0;
			addr_reg <= `DMX_ADDR_RST;
		end
		else if (take && pend_reg && dec_bus.dest_word)
		begin
			op_reg   <= DMX_OP_COPY2; // [RULE1]
			addr_reg <= dec_bus.far; // [RULE2]
		end
		else if (take)
		begin
			op_reg   <= dec_bus.op;
			dbit_reg <= dec_bus.dbit;
			case (dec_bus.op)
				DMX_OP_COPY1:
					addr_reg <= dec_bus.far; // [RULE2]
				DMX_OP_MOVE,
				DMX_OP_STORE:
					addr_reg <= res_addr; // [RULE9] [RULE10] [RULE11]
				default:
					addr_reg <= {`DMX_LIT_PAD, dec_bus.low};
			endcase
		end
		else if ((phase_reg == DMX_Q1) && !pend_reg)
			op_reg <= DMX_OP_NONE;
	end

	// Copy in flight: set at the first cycle's Q4, ended by next word
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pend_reg <= 1'b0;
		else if ((phase_reg == DMX_Q4) && (op_reg == DMX_OP_COPY1))
			pend_reg <= 1'b1; // [RULE1]
		else if (take)
			pend_reg <= 1'b0;
	end

	// One-clock notices; a lone 1111 word runs as a no-op
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			foreign_reg <= 1'b0;
			broken_reg  <= 1'b0;
		end
		else
		begin
			foreign_reg <= take && !dec_bus.dest_word &&
				(dec_bus.op == DMX_OP_NONE);
			broken_reg  <= take && pend_reg && !dec_bus.dest_word;
		end
	end

	// Operand capture in Q3; memory answers one clock after mem_re
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hold_reg <= `DMX_HOLD_RST;
		else if (phase_reg == DMX_Q3)
		begin
			case (op_reg)
				DMX_OP_MOVE,
				DMX_OP_COPY1:
					hold_reg <= addr_w ? acc_reg : mem_rdata; // [RULE3]
				DMX_OP_STORE:
					hold_reg <= acc_reg; // [RULE8]
				DMX_OP_LDBANK,
				DMX_OP_LDACC:
					hold_reg <= addr_reg[7:0];
				default:
					hold_reg <= hold_reg;
			endcase
		end
	end

	// Accumulator: literal, move result, or a write aimed at W_ADDR
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			acc_reg <= `DMX_ACC_RST;
		else if (phase_reg == DMX_Q4)
		begin
			if (op_reg == DMX_OP_LDACC)
				acc_reg <= hold_reg; // [RULE7]
			else if ((op_reg == DMX_OP_MOVE) && !dbit_reg)
				acc_reg <= hold_reg; // [RULE12]
			else if (wr_any && addr_w)
				acc_reg <= hold_reg; // [RULE3]
		end
	end

	// Bank selector keeps only the low nibble of the literal
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bank_reg <= `DMX_BANK_RST;
		else if ((phase_reg == DMX_Q4) && (op_reg == DMX_OP_LDBANK))
			bank_reg <= {`DMX_BANK_CLR, hold_reg[3:0]}; // [RULE5] [RULE6]
	end

	// Flags follow the register move only, others leave them
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			n_reg <= 1'b0;
			z_reg <= 1'b0;
		end
		else if ((phase_reg == DMX_Q4) && (op_reg == DMX_OP_MOVE))
		begin
			n_reg <= hold_reg[7]; // [RULE13] [RULE14]
			z_reg <= (hold_reg == `DMX_ZERO_BYTE); // [RULE13]
		end
	end

	// Checks on the sequencing and data paths
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_copy_first;
		take && !pend_reg && (dec_bus.op == DMX_OP_COPY1);
	endsequence
	sequence s_copy_second;
		take && pend_reg && dec_bus.dest_word;
	endsequence
	sequence s_ldbank;
		take && !pend_reg && (dec_bus.op == DMX_OP_LDBANK);
	endsequence
	sequence s_ldacc;
		take && !pend_reg && (dec_bus.op == DMX_OP_LDACC);
	endsequence
	sequence s_store;
		take && !(pend_reg && dec_bus.dest_word) &&
			(dec_bus.op == DMX_OP_STORE);
	endsequence

	property p_copy_pend;
		s_copy_first |-> ##4 (pend_reg && (phase_reg == DMX_Q1));
	endproperty
	a_copy_pend: assert property (p_copy_pend) // [RULE1]
		else $error("copy did not wait for its second word");

	property p_copy_write;
		s_copy_second |=> (op_reg == DMX_OP_COPY2) ##2
			((phase_reg == DMX_Q4) && wr_any);
	endproperty
	a_copy_write: assert property (p_copy_write) // [RULE1]
		else $error("copy second word did not write in Q4");

	property p_copy_src;
		((phase_reg == DMX_Q3) && (op_reg == DMX_OP_COPY1) && !addr_w)
			|=> (hold_reg == $past(mem_rdata));
	endproperty
	a_copy_src: assert property (p_copy_src) // [RULE2]
		else $error("copy source byte not captured");

	property p_copy_dst;
		((phase_reg == DMX_Q4) && (op_reg == DMX_OP_COPY2) && !addr_w)
			|-> (mem_we && (mem_wdata == hold_reg));
	endproperty
	a_copy_dst: assert property (p_copy_dst) // [RULE2]
		else $error("copy destination not written");

	property p_w_dst;
		((phase_reg == DMX_Q4) && (op_reg == DMX_OP_COPY2) && addr_w)
			|-> !mem_we ##1 (acc_reg == $past(hold_reg));
	endproperty
	a_w_dst: assert property (p_w_dst) // [RULE3]
		else $error("copy into accumulator went astray");

	property p_bank;
		s_ldbank |-> ##4
			(bank_reg == {`DMX_BANK_CLR, $past(instr_word[3:0], 4)});
	endproperty
	a_bank: assert property (p_bank) // [RULE5] [RULE6]
		else $error("bank selector load wrong");

	property p_ldacc;
		s_ldacc |-> ##4 (acc_reg == $past(instr_word[7:0], 4));
	endproperty
	a_ldacc: assert property (p_ldacc) // [RULE7]
		else $error("accumulator literal load wrong");

	property p_store;
		((phase_reg == DMX_Q4) && (op_reg == DMX_OP_STORE) && !addr_w)
			|-> (mem_we && (mem_wdata == acc_reg));
	endproperty
	a_store: assert property (p_store) // [RULE8]
		else $error("accumulator store data wrong");

	property p_access;
		(s_store and (!dec_bus.abit &&
			!(ext_set_en && (dec_bus.low <= `DMX_ILO_LIMIT))))
			|=> (addr_reg == (($past(dec_bus.low) < `DMX_ACCESS_SPLIT) ?
			{`DMX_ACCESS_LO, $past(dec_bus.low)} :
			{`DMX_ACCESS_HI, $past(dec_bus.low)}));
	endproperty
	a_access: assert property (p_access) // [RULE9]
		else $error("access bank address wrong");

	property p_banked;
		(s_store and dec_bus.abit)
			|=> (addr_reg == {bank_reg[3:0], $past(dec_bus.low)});
	endproperty
	a_banked: assert property (p_banked) // [RULE10]
		else $error("banked address wrong");

	property p_indexed;
		(s_store and (!dec_bus.abit && ext_set_en &&
			(dec_bus.low <= `DMX_ILO_LIMIT)))
			|=> (addr_reg == 12'($past(fsr2) +
			{`DMX_LIT_PAD, $past(dec_bus.low)}));
	endproperty
	a_indexed: assert property (p_indexed) // [RULE11]
		else $error("indexed offset address wrong");

	property p_move_acc;
		((phase_reg == DMX_Q4) && (op_reg == DMX_OP_MOVE) && !dbit_reg)
			|-> !mem_we ##1 (acc_reg == $past(hold_reg));
	endproperty
	a_move_acc: assert property (p_move_acc) // [RULE12]
		else $error("register move to accumulator wrong");

	property p_move_back;
		((phase_reg == DMX_Q4) && (op_reg == DMX_OP_MOVE) && dbit_reg &&
			!addr_w) |-> (mem_we && (mem_addr == addr_reg));
	endproperty
	a_move_back: assert property (p_move_back) // [RULE12]
		else $error("register move write-back missing");

	property p_move_flags;
		((phase_reg == DMX_Q4) && (op_reg == DMX_OP_MOVE)) |=>
			((z_reg == ($past(hold_reg) == `DMX_ZERO_BYTE)) &&
			(n_reg == $past(hold_reg[7])));
	endproperty
	a_move_flags: assert property (p_move_flags) // [RULE13]
		else $error("register move flags wrong");

	property p_flags_keep;
		((phase_reg == DMX_Q4) && (op_reg != DMX_OP_MOVE))
			|=> ($stable(n_reg) && $stable(z_reg));
	endproperty
	a_flags_keep: assert property (p_flags_keep) // [RULE14]
		else $error("flags changed by a flag-neutral move");
endmodule
`default_nettype wire

// ### core/dmx_pkg.sv
`default_nettype none
package dmx_pkg;
	// Four clock phases make one instruction cycle
	typedef enum logic [1:0]
	{
		DMX_Q1,
		DMX_Q2,
		DMX_Q3,
		DMX_Q4
	} dmx_phase_t;
	// Decoded operation of the current instruction cycle
	typedef enum logic [2:0]
	{
		DMX_OP_NONE,
		DMX_OP_MOVE,
		DMX_OP_COPY1,
		DMX_OP_COPY2,
		DMX_OP_LDBANK,
		DMX_OP_LDACC,
		DMX_OP_STORE
	} dmx_op_t;
endpackage
`default_nettype wire

// ### tb/data_move_instruction_exec_test.sv
`timescale 1ns/1ns
`default_nettype none
module data_move_instruction_exec_test;
	import dmx_pkg::*;
	typedef struct {logic [15:0] word; logic [7:0] acc; logic [7:0] bank;
		logic n; logic z; logic chk; logic [11:0] maddr; logic [7:0] mdata;
	} dmx_row_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] instr_word = 16'h0000;
	logic        instr_valid = 1'b0;
	logic        instr_ready;
	logic        ext_set_en = 1'b0;
	logic [11:0] fsr2 = 12'h000;
	logic [11:0] mem_addr;
	logic        mem_re;
	logic        mem_we;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic [7:0]  acc_value;
	logic [7:0]  bank_value;
	logic        flag_n;
	logic        flag_z;
	logic        foreign_word;
	logic        broken_copy;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	dmx_row_t    rows [12];

	always #10 clk = ~clk;

	dmx_move_exec u_dmx_move_exec (.clk(clk), .rst(rst),
		.instr_word(instr_word), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .ext_set_en(ext_set_en), .fsr2(fsr2),
		.mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.acc_value(acc_value), .bank_value(bank_value), .flag_n(flag_n),
		.flag_z(flag_z), .foreign_word(foreign_word),
		.broken_copy(broken_copy));

	dmx_mem_model u_dmx_mem_model (.clk(clk), .mem_addr(mem_addr),
		.mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Run is a few hundred cycles; ceiling leaves wide margin
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			$display("MISMATCH t=%0t run did not finish", $time);
			close_out();
		end
	end

	task automatic check8(string what, logic [7:0] got, logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check1(string what, logic got, logic exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	// Hold word and valid until the edge where ready is high, then drop
	task automatic issue(logic [15:0] w);
		int k;
		@(posedge clk);
		instr_word <= w;
		instr_valid <= 1'b1;
		#1;
		for (k = 0; k < 8 && instr_ready !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		instr_valid <= 1'b0;
	endtask

	// Past Q4 of the instruction just taken
	task automatic finish_cycle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic check_state(logic [7:0] a, logic [7:0] b, logic n,
		logic z);
		check8("acc", acc_value, a);
		check8("bank", bank_value, b);
		check1("neg", flag_n, n);
		check1("zero", flag_z, z);
	endtask

	function automatic logic [7:0] mem_at(logic [11:0] a);
		return u_dmx_mem_model.mem[a];
	endfunction

	initial
	begin
		// Word, acc, bank, n, z, memory check, address, byte
		rows = '{
			'{16'h0E5A, 8'h5A, 8'h00, 0, 0, 0, 12'h000, 8'h00},
			'{16'h01F3, 8'h5A, 8'h03, 0, 0, 0, 12'h000, 8'h00},
			'{16'h6F10, 8'h5A, 8'h03, 0, 0, 1, 12'h310, 8'h5A},
			'{16'h6E20, 8'h5A, 8'h03, 0, 0, 1, 12'h020, 8'h5A},
			'{16'h6E80, 8'h5A, 8'h03, 0, 0, 1, 12'hF80, 8'h5A},
			'{16'h0E00, 8'h00, 8'h03, 0, 0, 0, 12'h000, 8'h00},
			'{16'h5110, 8'h5A, 8'h03, 0, 0, 0, 12'h000, 8'h00},
			'{16'h5340, 8'h5A, 8'h03, 1, 0, 1, 12'h340, 8'h80},
			'{16'h5050, 8'h00, 8'h03, 0, 1, 0, 12'h000, 8'h00},
			'{16'h0105, 8'h00, 8'h05, 0, 1, 0, 12'h000, 8'h00},
			'{16'h0EFF, 8'hFF, 8'h05, 0, 1, 0, 12'h000, 8'h00},
			'{16'h6E5F, 8'hFF, 8'h05, 0, 1, 1, 12'h05F, 8'hFF}};
		u_dmx_mem_model.mem[12'h340] = 8'h80;
		u_dmx_mem_model.mem[12'h050] = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1;
		check_state(8'h00, 8'h00, 1'b0, 1'b0);
		$display("done reset values");
		// One-word group: literal loads, stores, register moves
		foreach (rows[i])
		begin
			issue(rows[i].word);
			finish_cycle();
			check_state(rows[i].acc, rows[i].bank, rows[i].n, rows[i].z);
			if (rows[i].chk)
				check8("mem", mem_at(rows[i].maddr), rows[i].mdata);
		end
		$display("done table rows");
		// Back to back copy; destinations avoid PC low and stack bytes
		issue(16'hC340);
		issue(16'hF456);
		finish_cycle();
		check8("copy", mem_at(12'h456), 8'h80);
		check_state(8'hFF, 8'h05, 1'b0, 1'b1);
		issue(16'hCFFF);
		issue(16'hF500);
		finish_cycle();
		check8("from acc", mem_at(12'h500), 8'hFF);
		issue(16'hC020);
		issue(16'hFFFF);
		finish_cycle();
		check8("into acc", acc_value, 8'h5A);
		// Second word arrives late; first must wait for it
		issue(16'hC310);
		repeat (7) @(posedge clk);
		issue(16'hF457);
		finish_cycle();
		check8("late copy", mem_at(12'h457), 8'h5A);
		$display("done copies");
		// Copy broken by a literal load, then a word outside the group
		issue(16'hC310);
		issue(16'h0E11);
		#1;
		check1("broken", broken_copy, 1'b1);
		finish_cycle();
		check8("acc", acc_value, 8'h11);
		issue(16'h0D05);
		#1;
		check1("foreign", foreign_word, 1'b1);
		finish_cycle();
		check8("acc", acc_value, 8'h11);
		$display("done odd words");
		// Indexed offset at and past the 5Fh boundary, then banked store
		@(posedge clk);
		ext_set_en <= 1'b1;
		fsr2 <= 12'h200;
		issue(16'h6E10);
		finish_cycle();
		check8("indexed", mem_at(12'h210), 8'h11);
		issue(16'h6E5F);
		finish_cycle();
		check8("indexed top", mem_at(12'h25F), 8'h11);
		issue(16'h6E60);
		finish_cycle();
		check8("access hi", mem_at(12'hF60), 8'h11);
		issue(16'h6F10);
		finish_cycle();
		check8("banked", mem_at(12'h510), 8'h11);
		ext_set_en <= 1'b0;
		$display("done extended");
		// Reset in mid-run clears the visible state
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check_state(8'h00, 8'h00, 1'b0, 1'b0);
		check1("write", mem_we, 1'b0);
		rst <= 1'b0;
		$display("done second reset");
		close_out();
	end
endmodule
`default_nettype wire

// ### tb/dmx_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module dmx_mem_model
(
	input  wire logic        clk,
	input  wire logic [11:0] mem_addr,
	input  wire logic        mem_re,
	input  wire logic        mem_we,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [4096];
	logic [7:0] rdata_reg = 8'hA5;

	// Byte store, written at the edge that ends the write strobe clock
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	end

	// Read data valid one clock only; otherwise toggles so stale bytes show
	always_ff @(posedge clk)
	begin
		if (mem_re)
			rdata_reg <= mem[mem_addr];
		else
			rdata_reg <= ~rdata_reg;
	end

	assign mem_rdata = rdata_reg;
endmodule
`default_nettype wire
